//--- include/fdfc_regs.vh
// register map, field positions, reset values and timing constants of the flash fault block
`ifndef FDFC_REGS_VH
`define FDFC_REGS_VH
`define FDFC_I2C_ADDR 7'h30
`define FDFC_ADDR_ID 8'h00
`define FDFC_ADDR_PINCFG 8'h02
`define FDFC_ADDR_OUTMODE 8'h04
`define FDFC_ADDR_FAULT 8'h05
`define FDFC_ADDR_PROT 8'h07
`define FDFC_PINCFG_RST 8'h0F
`define FDFC_OUTMODE_RST 8'hA4
`define FDFC_PROT_RST 8'h00
`define FDFC_FAULT_RST 8'h00
`define FDFC_ID_VALUE 8'h5A
`define FDFC_OM_PEAK_HI 7
`define FDFC_OM_PEAK_LO 6
`define FDFC_OM_TRIG_LVL 5
`define FDFC_OM_FREQ_FB 4
`define FDFC_OM_OUT_EN 3
`define FDFC_OM_TRIG_SRC 2
`define FDFC_PC_AUXB_HI 7
`define FDFC_PC_AUXB_LO 6
`define FDFC_PC_AUXA_HI 5
`define FDFC_PC_AUXA_LO 4
`define FDFC_PC_TIME_HI 3
`define FDFC_PROT_DYN_OV 7
`define FDFC_PROT_HARD_IL 0
`define FDFC_FLT_OVP 7
`define FDFC_FLT_SC 6
`define FDFC_FLT_OT 5
`define FDFC_FLT_TO 4
`define FDFC_FLT_TX1 3
`define FDFC_FLT_AUXB 2
`define FDFC_FLT_IL 1
`define FDFC_FLT_IDC 0
`define FDFC_FN_HIZ 2'h0
`define FDFC_FN_A_TORCH 2'h1
`define FDFC_FN_B_IND_LED 2'h1
`define FDFC_FN_MASK 2'h2
`define FDFC_FN_B_ANALOG 2'h3
`define FDFC_MODE_FLASH 2'h3
`define FDFC_CLK_MHZ 250
`define FDFC_FLASH_STEP_US 100000
`define FDFC_SOFT_START_US 600
`endif

//--- rtl/fdfc_i2c_slave.v
// i2c slave front end: byte framing, address match, register strobes
`timescale 1ns/1ps
`default_nettype none
`include "fdfc_regs.vh"
module fdfc_i2c_slave (
    // clock and reset
    input wire clk,
    input wire rst,
    // bus pins
    input wire scl_pin,
    input wire sda_pin,
    output reg sda_oe_q,
    // register side
    input wire [7:0] rd_data,
    output reg rd_pulse_q,
    output reg [7:0] reg_addr_q,
    output reg wr_pulse_q,
    output reg [7:0] wr_data_q
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_AACK = 4'h2;
    localparam [3:0] ST_SUB = 4'h3;
    localparam [3:0] ST_SACK = 4'h4;
    localparam [3:0] ST_WDAT = 4'h5;
    localparam [3:0] ST_WACK = 4'h6;
    localparam [3:0] ST_RDAT = 4'h7;
    localparam [3:0] ST_RACK = 4'h8;

    reg [2:0] scl_q;
    reg [2:0] sda_q;
    reg [3:0] st_q;
    reg [3:0] cnt_q;
    reg [7:0] sh_q;
    reg [7:0] tx_q;
    reg rw_q;
    reg ack_q;
    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    wire stop_cond = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // first stage feeds only the second; edges are taken between stages two and three
    always @(posedge clk)
    begin
        scl_q <= {scl_q[1:0], scl_pin};
        sda_q <= {sda_q[1:0], sda_pin};
    end

    always @(posedge clk)
    begin
        rd_pulse_q <= 1'b0;
        wr_pulse_q <= 1'b0;
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            reg_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end
        else if (start_cond)
        begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end
        else if (stop_cond)
        begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (st_q == ST_ADDR || st_q == ST_SUB || st_q == ST_WDAT)
            begin
                sh_q <= {sh_q[6:0], sda_q[1]};
                cnt_q <= cnt_q + 4'h1;
            end
            if (st_q == ST_RACK)
                ack_q <= ~sda_q[1];
        end
        else if (scl_fall)
        begin
            case (st_q)
                ST_ADDR:
                    if (cnt_q == 4'h8)
                    begin
                        if (sh_q[7:1] == `FDFC_I2C_ADDR)
                        begin
                            sda_oe_q <= 1'b1;
                            rw_q <= sh_q[0];
                            st_q <= ST_AACK;
                        end
                        else
                            st_q <= ST_IDLE;
                    end
                ST_AACK, ST_RACK:
                    if (rw_q && (st_q == ST_AACK || ack_q))
                    begin
                        // the byte is loaded now; its read side effect lands one cycle later
                        tx_q <= rd_data;
                        sda_oe_q <= ~rd_data[7];
                        rd_pulse_q <= 1'b1;
                        cnt_q <= 4'h1;
                        st_q <= ST_RDAT;
                    end
                    else if (!rw_q)
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= ST_SUB;
                    end
                    else
                    begin
                        sda_oe_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                ST_SUB:
                    if (cnt_q == 4'h8)
                    begin
                        reg_addr_q <= sh_q;
                        sda_oe_q <= 1'b1;
                        st_q <= ST_SACK;
                    end
                ST_SACK, ST_WACK:
                begin
                    sda_oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                    st_q <= ST_WDAT;
                    if (st_q == ST_WACK)
                        reg_addr_q <= reg_addr_q + 8'h01;
                end
                ST_WDAT:
                    if (cnt_q == 4'h8)
                    begin
                        wr_data_q <= sh_q;
                        wr_pulse_q <= 1'b1;
                        sda_oe_q <= 1'b1;
                        st_q <= ST_WACK;
                    end
                ST_RDAT:
                    if (cnt_q == 4'h8)
                    begin
                        sda_oe_q <= 1'b0;
                        reg_addr_q <= reg_addr_q + 8'h01;
                        st_q <= ST_RACK;
                    end
                    else
                    begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                        cnt_q <= cnt_q + 4'h1;
                    end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // fdfc_i2c_slave
`default_nettype wire

//--- rtl/fdfc_top.v
// flash driver fault supervision and configuration registers behind an i2c slave
// Functional notes
// - critical fault clears output enable, stops driver, sets its fault bit
// - reading fault register clears the bits it returned; enable edge, undervoltage and reset also clear
// - non-critical events keep driver running, bits held until read
// - led short while driving sets bit 6, locks off until cleared
// - overvoltage trip shuts down, sets bit 7, locks off until cleared
// - dynamic overvoltage enable turns overvoltage into clamping, not fault
// - hardware level strobe held past flash time sets bit 4, locks off
// - thermal trip shuts down, sets bit 5, locks off until cleared
// - aux pin b indicator led fault sets bit 2
// - soft limit mode: peak limit sets bit 1, freezes current rise
// - hard limit mode: peak limit sets bit 1 and locks off
// - peak limit setting comes from output mode bits 7:6
// - undervoltage shuts down; registers return to defaults on recovery
// - soft start ramps output level, finished within 0.6 ms
// - enable pin rising edge restores all registers to defaults
// - slave answers at 7-bit address 0x30
// - single write is subaddress then one data byte, acknowledged
// - register 0x00 reads a fixed identification code
// - pin config bits 7:6 select aux pin b function
// - pin config bits 5:4 select aux pin a function
// - pin config bits 3:0 give flash time (code+1) x 100 ms
// - bit 3 records mask one during flash, bit 0 dc limit hit
// - with output mode bit 2 set, strobe level sensitive when bit 5 set, else edge; bit 2 clear starts flash without strobe
`timescale 1ns/1ps
`default_nettype none
`include "fdfc_regs.vh"
module fdfc_top #(
    parameter FLASH_STEP_CYCLES = `FDFC_FLASH_STEP_US * `FDFC_CLK_MHZ,
    parameter SOFT_START_CYCLES = `FDFC_SOFT_START_US * `FDFC_CLK_MHZ,
    // arbitrary identification value
    parameter [7:0] ID_CODE = `FDFC_ID_VALUE
) (
    // clock and reset
    input wire REF_CLK,
    input wire SRST,
    // i2c pins
    input wire SCL,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE,
    // supply and control pins
    input wire EN_PIN,
    input wire BAT_UNDERVOLT,
    input wire STROBE,
    input wire AUX_PIN_A_IN,
    input wire AUX_PIN_B_IN,
    // analog monitor indications
    input wire OVERVOLT_TRIP,
    input wire LED_SHORT,
    input wire OVER_TEMP,
    input wire PEAK_ILIM,
    input wire DC_ILIM,
    input wire IND_LED_FAULT,
    // power stage control
    output reg DRIVER_ON,
    output reg [1:0] LED_MODE,
    output reg [1:0] PEAK_LIMIT_SEL,
    output reg FREQ_FOLDBACK,
    output reg CURRENT_FREEZE,
    output reg OV_CLAMP,
    output reg [7:0] SOFT_START_LEVEL,
    output reg FLASH_ACTIVE,
    // aux pin control
    output reg TORCH_REQ,
    output reg IND_LED_EN,
    output reg MASK_ONE_ACTIVE,
    output reg MASK_TWO_ACTIVE,
    output reg ADC_EXT_SEL
);
    localparam integer SS_STEP_RAW = SOFT_START_CYCLES / 256;
    localparam integer SS_STEP = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;
    localparam integer NSYNC = 11;

    function is_fn;
        input [1:0] cfg;
        input [1:0] code;
        begin
            is_fn = (cfg == code);
        end
    endfunction

    // pin synchronisers
    wire [NSYNC-1:0] pin_raw = {EN_PIN, BAT_UNDERVOLT, STROBE, AUX_PIN_A_IN, AUX_PIN_B_IN,
        OVERVOLT_TRIP, LED_SHORT, OVER_TEMP, PEAK_ILIM, DC_ILIM, IND_LED_FAULT};
    reg [NSYNC-1:0] meta_q;
    reg [NSYNC-1:0] sync_q;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always @(posedge REF_CLK)
            begin
                meta_q[gi] <= pin_raw[gi];
                sync_q[gi] <= meta_q[gi];
            end
        end
    endgenerate
    wire en_s = sync_q[10];
    wire uv_s = sync_q[9];
    wire strobe_s = sync_q[8];
    wire auxa_s = sync_q[7];
    wire auxb_s = sync_q[6];
    wire ov_s = sync_q[5];
    wire short_s = sync_q[4];
    wire ot_s = sync_q[3];
    wire peak_s = sync_q[2];
    wire dc_s = sync_q[1];
    wire iled_s = sync_q[0];

    reg en_prev_q;
    reg strobe_prev_q;
    wire en_rise = en_s & ~en_prev_q;
    wire strobe_rise = strobe_s & ~strobe_prev_q;
    // undervoltage holds registers at default, so they come back clean when it lifts
    wire reg_rst = SRST | en_rise | uv_s;

    // bus slave
    wire rd_pulse;
    wire wr_pulse;
    wire [7:0] reg_addr;
    wire [7:0] wr_data;
    reg [7:0] rd_data;
    reg sda_out_q;
    fdfc_i2c_slave u_i2c (
        .clk(REF_CLK),
        .rst(SRST),
        .scl_pin(SCL),
        .sda_pin(SDA_IN),
        .sda_oe_q(SDA_OE),
        .rd_data(rd_data),
        .rd_pulse_q(rd_pulse),
        .reg_addr_q(reg_addr),
        .wr_pulse_q(wr_pulse),
        .wr_data_q(wr_data)
    );
    assign SDA_OUT = sda_out_q;

    reg [7:0] pincfg_q;
    reg [7:0] outmode_q;
    reg [7:0] prot_q;
    reg [7:0] fault_q;
    reg [7:0] shown_q;
    reg lock_q;
    reg flash_q;
    reg [24:0] pre_q;
    reg [3:0] steps_q;
    reg [9:0] ss_pre_q;

    always @*
    begin
        case (reg_addr)
            `FDFC_ADDR_ID: rd_data = ID_CODE;
            `FDFC_ADDR_PINCFG: rd_data = pincfg_q;
            `FDFC_ADDR_OUTMODE: rd_data = outmode_q;
            `FDFC_ADDR_FAULT: rd_data = fault_q;
            `FDFC_ADDR_PROT: rd_data = prot_q;
            default: rd_data = 8'h00;
        endcase
    end

    // decoded configuration
    wire [1:0] auxb_fn = pincfg_q[`FDFC_PC_AUXB_HI:`FDFC_PC_AUXB_LO];
    wire [1:0] auxa_fn = pincfg_q[`FDFC_PC_AUXA_HI:`FDFC_PC_AUXA_LO];
    wire [3:0] flash_time = pincfg_q[`FDFC_PC_TIME_HI:0];
    wire out_en = outmode_q[`FDFC_OM_OUT_EN];
    wire hw_trig = outmode_q[`FDFC_OM_TRIG_SRC];
    wire lvl_trig = outmode_q[`FDFC_OM_TRIG_LVL];
    wire [1:0] led_mod = outmode_q[1:0];
    wire dyn_ov = prot_q[`FDFC_PROT_DYN_OV];
    wire hard_il = prot_q[`FDFC_PROT_HARD_IL];
    wire run_ok = out_en & ~lock_q & en_s;
    wire flash_mode = run_ok & (led_mod == `FDFC_MODE_FLASH);
    wire drv_on = run_ok & (led_mod != 2'h0) & (flash_q | (led_mod != `FDFC_MODE_FLASH));

    // flash timer in 100 ms steps
    wire step_tick = flash_q & (pre_q == FLASH_STEP_CYCLES - 1);
    wire expire = step_tick & (steps_q == flash_time);
    wire level_mode = hw_trig & lvl_trig;
    wire timeout = flash_q & level_mode & expire;
    wire sw_done = flash_q & ~hw_trig & expire;
    reg flash_d;
    always @*
    begin
        if (!flash_mode)
            flash_d = 1'b0;
        else if (level_mode)
            flash_d = strobe_s & ~timeout;
        else if (flash_q)
            flash_d = ~expire;
        else
            flash_d = hw_trig ? strobe_rise : 1'b1;
    end

    // event collection
    reg [7:0] set_v;
    always @*
    begin
        set_v = 8'h00;
        set_v[`FDFC_FLT_OVP] = ov_s & drv_on & ~dyn_ov;
        set_v[`FDFC_FLT_SC] = short_s & drv_on;
        set_v[`FDFC_FLT_OT] = ot_s;
        set_v[`FDFC_FLT_TO] = timeout;
        set_v[`FDFC_FLT_TX1] = flash_q & is_fn(auxa_fn, `FDFC_FN_MASK) & auxa_s;
        set_v[`FDFC_FLT_AUXB] = (is_fn(auxb_fn, `FDFC_FN_B_IND_LED) & iled_s)
            | (flash_q & is_fn(auxb_fn, `FDFC_FN_MASK) & auxb_s);
        set_v[`FDFC_FLT_IL] = peak_s & drv_on;
        set_v[`FDFC_FLT_IDC] = dc_s & drv_on;
    end
    wire crit = set_v[`FDFC_FLT_OVP] | set_v[`FDFC_FLT_SC] | set_v[`FDFC_FLT_OT]
        | set_v[`FDFC_FLT_TO] | (set_v[`FDFC_FLT_IL] & hard_il);
    wire fault_rd = rd_pulse & (reg_addr == `FDFC_ADDR_FAULT);
    wire reg_wr = wr_pulse & ~reg_rst;

    always @(posedge REF_CLK)
    begin
        en_prev_q <= en_s;
        strobe_prev_q <= strobe_s;
        // the read pulse trails the byte load by one cycle; this is what the host got
        shown_q <= fault_q;
        sda_out_q <= 1'b0;
        if (reg_rst)
        begin
            pincfg_q <= `FDFC_PINCFG_RST;
            outmode_q <= `FDFC_OUTMODE_RST;
            prot_q <= `FDFC_PROT_RST;
            fault_q <= `FDFC_FAULT_RST;
            lock_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `FDFC_ADDR_PINCFG)
                pincfg_q <= wr_data;
            if (reg_wr && reg_addr == `FDFC_ADDR_PROT)
                prot_q <= wr_data;
            // hardware shutdown wins over a write landing in the same cycle
            if (crit || sw_done)
                outmode_q <= {outmode_q[7:4], 1'b0, outmode_q[2:0]};
            else if (reg_wr && reg_addr == `FDFC_ADDR_OUTMODE)
                outmode_q <= wr_data;
            // read clears exactly what was shown; a same-cycle event survives
            if (fault_rd)
                fault_q <= (fault_q & ~shown_q) | set_v;
            else
                fault_q <= fault_q | set_v;
            if (crit)
                lock_q <= 1'b1;
            else if (fault_rd)
                lock_q <= 1'b0;
        end
    end

    // flash timer and soft start ramp
    wire freeze = (peak_s & ~hard_il | dc_s) & drv_on;
    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            flash_q <= 1'b0;
            pre_q <= 25'h0000000;
            steps_q <= 4'h0;
            ss_pre_q <= 10'h000;
        end
        else
        begin
            flash_q <= flash_d;
            if (!flash_q || !flash_d || step_tick)
                pre_q <= 25'h0000000;
            else
                pre_q <= pre_q + 25'h0000001;
            if (!flash_q || !flash_d)
                steps_q <= 4'h0;
            else if (step_tick)
                steps_q <= steps_q + 4'h1;
            if (!drv_on || ss_pre_q == SS_STEP - 1)
                ss_pre_q <= 10'h000;
            else
                ss_pre_q <= ss_pre_q + 10'h001;
        end
    end

    // registered outputs
    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            DRIVER_ON <= 1'b0;
            LED_MODE <= 2'h0;
            PEAK_LIMIT_SEL <= 2'h2;
            FREQ_FOLDBACK <= 1'b0;
            CURRENT_FREEZE <= 1'b0;
            OV_CLAMP <= 1'b0;
            SOFT_START_LEVEL <= 8'h00;
            FLASH_ACTIVE <= 1'b0;
            TORCH_REQ <= 1'b0;
            IND_LED_EN <= 1'b0;
            MASK_ONE_ACTIVE <= 1'b0;
            MASK_TWO_ACTIVE <= 1'b0;
            ADC_EXT_SEL <= 1'b0;
        end
        else
        begin
            DRIVER_ON <= drv_on & ~crit & ~uv_s;
            LED_MODE <= led_mod;
            PEAK_LIMIT_SEL <= outmode_q[`FDFC_OM_PEAK_HI:`FDFC_OM_PEAK_LO];
            FREQ_FOLDBACK <= outmode_q[`FDFC_OM_FREQ_FB];
            CURRENT_FREEZE <= freeze;
            OV_CLAMP <= ov_s & drv_on & dyn_ov;
            // ramp pauses while a limit holds current; 256 steps fit the start window
            if (!drv_on)
                SOFT_START_LEVEL <= 8'h00;
            else if (!freeze && ss_pre_q == SS_STEP - 1 && SOFT_START_LEVEL != 8'hFF)
                SOFT_START_LEVEL <= SOFT_START_LEVEL + 8'h01;
            FLASH_ACTIVE <= flash_q;
            TORCH_REQ <= is_fn(auxa_fn, `FDFC_FN_A_TORCH) & auxa_s;
            IND_LED_EN <= is_fn(auxb_fn, `FDFC_FN_B_IND_LED);
            MASK_ONE_ACTIVE <= is_fn(auxa_fn, `FDFC_FN_MASK) & auxa_s;
            MASK_TWO_ACTIVE <= is_fn(auxb_fn, `FDFC_FN_MASK) & auxb_s;
            ADC_EXT_SEL <= is_fn(auxb_fn, `FDFC_FN_B_ANALOG);
        end
    end
endmodule // fdfc_top
`default_nettype wire

//--- bench/fdfc_asserts.sv
// port checker of the flash fault and configuration block
`timescale 1ns/1ps
`default_nettype none
module fdfc_asserts #(
    parameter SOFT_START_CYCLES = 512
) (
    // clock and reset
    input wire REF_CLK,
    input wire SRST,
    // pins and monitors
    input wire EN_PIN,
    input wire BAT_UNDERVOLT,
    input wire OVERVOLT_TRIP,
    input wire LED_SHORT,
    input wire OVER_TEMP,
    input wire PEAK_ILIM,
    // power stage and aux outputs
    input wire DRIVER_ON,
    input wire [1:0] PEAK_LIMIT_SEL,
    input wire CURRENT_FREEZE,
    input wire OV_CLAMP,
    input wire [7:0] SOFT_START_LEVEL,
    input wire IND_LED_EN,
    input wire MASK_TWO_ACTIVE,
    input wire ADC_EXT_SEL
);
    // margin over the ramp length for the pin sync and step rounding
    localparam int SS_MAX = SOFT_START_CYCLES + SOFT_START_CYCLES / 8 + 4;
    default clocking dc @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    ot_stop_a: assert property (OVER_TEMP [*4] |-> ##[0:2] !DRIVER_ON)
        else $error("driver ran on in overtemperature");
    ovp_stop_a: assert property ((DRIVER_ON && OVERVOLT_TRIP) [*4] |-> ##[0:2] (!DRIVER_ON || OV_CLAMP))
        else $error("overvoltage neither stopped nor clamped");
    short_stop_a: assert property ((DRIVER_ON && LED_SHORT) [*4] |-> ##[0:2] !DRIVER_ON)
        else $error("led short did not stop driver");
    peak_limit_a: assert property ((DRIVER_ON && PEAK_ILIM) [*4] |-> ##[0:2] (CURRENT_FREEZE || !DRIVER_ON))
        else $error("peak limit ignored");
    no_clamp_a: assert property (!OVERVOLT_TRIP [*5] |-> !OV_CLAMP)
        else $error("clamp without overvoltage");
    uv_hold_a: assert property (BAT_UNDERVOLT [*5] |-> (!DRIVER_ON && PEAK_LIMIT_SEL == 2'h2))
        else $error("undervoltage did not hold defaults");
    en_reset_a: assert property ($rose(EN_PIN) |-> ##[2:6] PEAK_LIMIT_SEL == 2'h2)
        else $error("enable edge did not restore defaults");
    ss_done_a: assert property ($rose(DRIVER_ON) |-> ##[1:SS_MAX] (SOFT_START_LEVEL == 8'hFF || !DRIVER_ON))
        else $error("soft start too long");
    aux_b_one_a: assert property ($onehot0({IND_LED_EN, MASK_TWO_ACTIVE, ADC_EXT_SEL}))
        else $error("aux pin b has two functions");
    rst_dflt_a: assert property (@(posedge REF_CLK) disable iff (1'b0) SRST |=> (!DRIVER_ON && PEAK_LIMIT_SEL == 2'h2))
        else $error("reset defaults wrong");
endmodule // fdfc_asserts

bind fdfc_top fdfc_asserts #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) fdfc_asserts_i (.REF_CLK, .SRST,
    .EN_PIN, .BAT_UNDERVOLT, .OVERVOLT_TRIP, .LED_SHORT, .OVER_TEMP, .PEAK_ILIM, .DRIVER_ON,
    .PEAK_LIMIT_SEL, .CURRENT_FREEZE, .OV_CLAMP, .SOFT_START_LEVEL, .IND_LED_EN, .MASK_TWO_ACTIVE,
    .ADC_EXT_SEL);
`default_nettype wire

//--- bench/fdfc_host_master.sv
// host processor model: i2c master on an open-drain data line
`timescale 1ns/1ps
`default_nettype none
module fdfc_host_master (
    // bus pins
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // quarter of the 32 ns link period; clock stands high between frames
    localparam time Q = 8;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // data moves only while scl is low; released data floats to the pull-up
    task automatic bit_io(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #(2 * Q) r = sda;
        scl = 1'b0;
    endtask
    // serves as first and repeated start alike
    task automatic start;
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask
    task automatic stop;
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] dev, sub, dat, output logic ok);
        logic a0, a1, a2;
        start();
        tx(dev, a0);
        tx(sub, a1);
        tx(dat, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // single read ends with no acknowledge from the host
    task automatic rd(input logic [7:0] sub, output logic [7:0] d, output logic ok);
        logic a0, a1, a2, r;
        start();
        tx(8'h60, a0);
        tx(sub, a1);
        start();
        tx(8'h61, a2);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // fdfc_host_master
`default_nettype wire

//--- bench/tb_flash_driver_fault_and_config.sv
// self-checking bench of the flash fault and configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_driver_fault_and_config;
    localparam int STEP = 16;
    // arbitrary identification value
    localparam logic [7:0] ID = 8'hC3;
    typedef struct {logic [7:0] sub; logic [7:0] wd; logic [7:0] rd;} fdfc_row_t;
    // writes to read-only, unmapped and fault places must not stick
    fdfc_row_t rows [6] = '{'{8'h02, 8'hA5, 8'hA5}, '{8'h07, 8'h81, 8'h81}, '{8'h04, 8'h40, 8'h40},
        '{8'h00, 8'hFF, ID}, '{8'h01, 8'h77, 8'h00}, '{8'h05, 8'hFF, 8'h00}};
    logic [7:0] fexp [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b1;
    logic uv = 1'b0;
    logic strobe = 1'b0;
    logic [1:0] aux = 2'b11;
    logic [5:0] mon = 6'h00;
    logic scl, m_low, sda_oe, ok, drv, freeze, clamp, flash, torch, iled, adc, m1;
    logic [7:0] d;
    logic [1:0] pk, lm;
    int failures = 0;
    int checked = 0;
    wire logic sda = ~(m_low | sda_oe);

    always #2 ref_clk = ~ref_clk;

    fdfc_top #(.FLASH_STEP_CYCLES(STEP), .SOFT_START_CYCLES(512), .ID_CODE(ID)) fdfc_top_i (
        .REF_CLK(ref_clk), .SRST(srst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
        .EN_PIN(en), .BAT_UNDERVOLT(uv), .STROBE(strobe), .AUX_PIN_A_IN(aux[0]),
        .AUX_PIN_B_IN(aux[1]), .OVERVOLT_TRIP(mon[5]), .LED_SHORT(mon[4]), .OVER_TEMP(mon[3]),
        .PEAK_ILIM(mon[2]), .DC_ILIM(mon[1]), .IND_LED_FAULT(mon[0]), .DRIVER_ON(drv),
        .LED_MODE(lm), .PEAK_LIMIT_SEL(pk), .FREQ_FOLDBACK(), .CURRENT_FREEZE(freeze),
        .OV_CLAMP(clamp), .SOFT_START_LEVEL(), .FLASH_ACTIVE(flash), .TORCH_REQ(torch),
        .IND_LED_EN(iled), .MASK_ONE_ACTIVE(m1), .MASK_TWO_ACTIVE(), .ADC_EXT_SEL(adc));
    fdfc_host_master fdfc_host_master_i (.scl(scl), .sda_low(m_low), .sda(sda));

    task automatic summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] sub, dat);
        fdfc_host_master_i.wr(8'h60, sub, dat, ok);
        chk({7'h00, ok}, 8'h01, "write ack");
        cyc(1);
    endtask
    task automatic r(input logic [7:0] sub, exp, input string what);
        fdfc_host_master_i.rd(sub, d, ok);
        cyc(1);
        chk(d, exp, what);
    endtask
    // bounded wait: the registered driver output trails the mode write
    task automatic wait_drv;
        int n;
        n = 0;
        while (drv !== 1'b1 && n < 2000)
        begin
            cyc(1);
            n++;
        end
        if (n == 2000)
        begin
            failures++;
            $display("MISMATCH t=%0t driver never started", $time);
            summarize();
        end
    endtask

    initial
    begin
        int k;
        cyc(8);
        srst = 1'b0;
        cyc(4);
        r(8'h02, 8'h0F, "reset pin config");
        r(8'h04, 8'hA4, "reset output mode");
        r(8'h05, 8'h00, "reset faults");
        chk({6'h00, pk}, 8'h02, "reset peak");
        foreach (rows[i])
        begin
            w(rows[i].sub, rows[i].wd);
            r(rows[i].sub, rows[i].rd, "register row");
        end
        chk({6'h00, pk}, 8'h01, "peak select");
        $display("test registers done");
        for (k = 0; k < 4; k++)
        begin
            w(8'h02, {k[1:0], k[1:0], 4'hF});
            cyc(6);
            chk({5'h00, torch, iled, adc}, {5'h00, k == 1, k == 1, k == 3}, "aux decode");
            chk({7'h00, m1}, {7'h00, k == 2}, "mask one decode");
        end
        w(8'h02, 8'h40);
        mon[0] = 1'b1;
        cyc(8);
        mon = 6'h00;
        r(8'h05, 8'h04, "indicator fault");
        $display("test aux done");
        w(8'h07, 8'h01);
        for (k = 0; k < 4; k++)
        begin
            w(8'h04, 8'hAA);
            wait_drv();
            mon[5 - k] = 1'b1;
            cyc(8);
            chk({5'h00, lm, drv}, 8'h04, "critical stop");
            mon = 6'h00;
            r(8'h04, 8'hA2, "enable cleared");
            r(8'h05, fexp[k], "fault bit");
            r(8'h05, 8'h00, "fault cleared");
        end
        $display("test critical done");
        w(8'h07, 8'h00);
        w(8'h04, 8'hAA);
        wait_drv();
        mon[2:1] = 2'b11;
        cyc(8);
        chk({6'h00, freeze, drv}, 8'h03, "soft limit runs");
        mon = 6'h00;
        r(8'h05, 8'h03, "soft limit flags");
        w(8'h07, 8'h80);
        mon[5] = 1'b1;
        cyc(8);
        chk({6'h00, clamp, drv}, 8'h03, "dynamic clamp");
        mon = 6'h00;
        r(8'h05, 8'h00, "no overvoltage fault");
        $display("test noncritical done");
        w(8'h07, 8'h00);
        w(8'h04, 8'hAF);
        strobe = 1'b1;
        cyc(STEP + 40);
        chk({7'h00, drv}, 8'h00, "strobe timeout");
        strobe = 1'b0;
        r(8'h05, 8'h10, "timeout bit");
        w(8'h04, 8'h8F);
        strobe = 1'b1;
        cyc(4);
        strobe = 1'b0;
        cyc(6);
        chk({7'h00, flash}, 8'h01, "edge flash runs");
        cyc(STEP + 10);
        chk({7'h00, flash}, 8'h00, "edge flash ends");
        $display("test flash done");
        w(8'h04, 8'h40);
        en = 1'b0;
        cyc(6);
        en = 1'b1;
        cyc(8);
        chk({6'h00, pk}, 8'h02, "enable pin reset");
        r(8'h02, 8'h0F, "enable pin reset");
        w(8'h02, 8'h33);
        uv = 1'b1;
        cyc(8);
        uv = 1'b0;
        cyc(8);
        r(8'h02, 8'h0F, "undervoltage reset");
        fdfc_host_master_i.wr(8'h62, 8'h02, 8'h11, ok);
        chk({7'h00, ok}, 8'h00, "foreign address");
        r(8'h02, 8'h0F, "foreign write dropped");
        $display("test resets done");
        summarize();
    end
endmodule // tb_flash_driver_fault_and_config
`default_nettype wire
